// File: adc_seq_pkg.sv
// Constants for the conversion sequencer
package adc_seq_pkg;
  localparam int DATA_W          = 10;
  localparam int CONV_CLKS       = 14;
  localparam int ACQ_MIN_X10     = 45;
  localparam int ACQ_MAX_X10     = 55;
  localparam int ACQ_CLKS        = (ACQ_MIN_X10 + ACQ_MAX_X10) / 20;
  localparam int CTL_DUAL_BIT    = 6;
  localparam int CTL_POL_BIT     = 9;
  localparam int CLK_DIV         = 4;
  localparam logic [9:0] CTL_RESET = 10'h000;
  localparam logic [9:0] INVALID_DATA = 10'h3FF;
endpackage : adc_seq_pkg

// File: pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic ref_clk,
  input  wire logic arst_n,
  input  wire logic pin_in,
  output logic      level_out
);
  logic [2:0] stage_r;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage_r <= {3{RESET_VAL}};
    end else begin
      stage_r <= {stage_r[1:0], pin_in};
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      level_out <= RESET_VAL;
    end else if (stage_r[1] == stage_r[2]) begin
      level_out <= stage_r[2];
    end
  end
endmodule : pin_sync
`default_nettype wire

// File: adc_seq.sv
// Conversion sequencer with parallel host port and abort behaviour
// Function
// R1: Read during conversion aborts, returns invalid data
// R2: Host withholds reads while busy
// R3: Write aborts; write fall drives busy
// R4: After abort, acquire then fresh sequence
// R5: Each conversion takes 14 master clocks
// R6: Acquire 4.5 to 5.5 clocks after write
// R7: Single mode: signal done, store first
// R8: Dual mode: second conversion, then signal
// R9: Write loads control register, starts conversion
// R10: Dual reads alternate first/second registers
// R11: Busy held from write fall to end
`timescale 1ns/1ps
`default_nettype none
module adc_seq
  import adc_seq_pkg::*;
#(
  parameter int DW = DATA_W
) (
  // Clock and reset
  input  wire logic          ref_clk,
  input  wire logic          arst_n,
  // Master clock pin
  input  wire logic          master_clock_input,
  // Host strobes, active low
  input  wire logic          cs_n,
  input  wire logic          wr_n,
  input  wire logic          rd_n,
  // Data port
  input  wire logic [DW-1:0] data_in,
  output logic      [DW-1:0] data_out,
  output logic               data_oe,
  // Converter core result bits
  input  wire logic [DW-1:0] core_sample,
  // Status and control
  output logic               busy_int,
  output logic      [DW-1:0] ctl_out,
  output logic      [DW-1:0] first_result_reg,
  output logic      [DW-1:0] second_result_reg
);
  if (DW != DATA_W || CONV_CLKS > 32 || ACQ_CLKS < 1 || ACQ_CLKS > 32) begin : g_param_check
    $error("adc_seq: DW must equal DATA_W and counts must fit the 5-bit counter");
  end

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_HOLD  = 4'b0010,
    ST_ACQ   = 4'b0100,
    ST_CONV  = 4'b1000
  } state_type;

  ////////////////////////////////////////////////////////////////////////////
  logic mclk_s, cs_s, wr_s, rd_s;
  logic mclk_d_r, wr_d_r, rd_d_r;
  logic [DW-1:0] din_s1_r, din_s2_r;

  pin_sync #(.RESET_VAL(1'b0)) u_mclk (.ref_clk(ref_clk), .arst_n(arst_n), .pin_in(master_clock_input),
                                       .level_out(mclk_s));
  pin_sync #(.RESET_VAL(1'b1)) u_cs (.ref_clk(ref_clk), .arst_n(arst_n), .pin_in(cs_n), .level_out(cs_s));
  pin_sync #(.RESET_VAL(1'b1)) u_wr (.ref_clk(ref_clk), .arst_n(arst_n), .pin_in(wr_n), .level_out(wr_s));
  pin_sync #(.RESET_VAL(1'b1)) u_rd (.ref_clk(ref_clk), .arst_n(arst_n), .pin_in(rd_n), .level_out(rd_s));

  // Data bus delayed to line up with filtered strobes
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      din_s1_r <= '0;
      din_s2_r <= '0;
    end else begin
      din_s1_r <= data_in;
      din_s2_r <= din_s1_r;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mclk_d_r <= 1'b0;
      wr_d_r   <= 1'b1;
      rd_d_r   <= 1'b1;
    end else begin
      mclk_d_r <= mclk_s;
      wr_d_r   <= wr_s;
      rd_d_r   <= rd_s;
    end
  end

  logic mclk_tick, wr_fall, wr_rise, rd_fall, rd_rise;
  assign mclk_tick = mclk_s & ~mclk_d_r;
  assign wr_fall   = ~cs_s & rd_s & wr_d_r & ~wr_s;
  assign wr_rise   = ~wr_d_r & wr_s;
  assign rd_fall   = ~cs_s & wr_s & rd_d_r & ~rd_s;
  assign rd_rise   = ~rd_d_r & rd_s;

  ////////////////////////////////////////////////////////////////////////////
  state_type state_r;
  logic [4:0] cnt_r;
  logic       second_r;
  logic [DW-1:0] ctl_r;
  logic [DW-1:0] approx_r;
  logic       done_pulse;
  logic       dual;
  assign dual = ctl_r[CTL_DUAL_BIT];
  assign done_pulse = (state_r == ST_CONV) && mclk_tick && (cnt_r == 5'(CONV_CLKS - 1))
                      && (!dual || second_r);

  // Control register load on write fall
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl_r <= CTL_RESET;
    end else if (wr_fall) begin
      ctl_r <= din_s2_r; // R9
    end
  end

  // Sequencer
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r  <= ST_IDLE;
      cnt_r    <= '0;
      second_r <= 1'b0;
      approx_r <= '0;
    end else if (wr_fall) begin
      state_r  <= ST_HOLD; // R3 R4 R9
      cnt_r    <= '0;
      second_r <= 1'b0;
      approx_r <= '0;
    end else if (rd_fall && state_r != ST_IDLE) begin
      state_r  <= ST_IDLE; // R1
      cnt_r    <= '0;
      second_r <= 1'b0;
      approx_r <= '0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          cnt_r <= '0;
        end
        ST_HOLD: begin
          if (wr_rise) begin
            state_r <= ST_ACQ;
            cnt_r   <= '0;
          end
        end
        ST_ACQ: begin
          if (mclk_tick) begin
            if (cnt_r == 5'(ACQ_CLKS - 1)) begin
              state_r <= ST_CONV; // R6
              cnt_r   <= '0;
            end else begin
              cnt_r <= cnt_r + 5'd1;
            end
          end
        end
        ST_CONV: begin
          if (mclk_tick) begin
            approx_r <= core_sample;
            if (cnt_r == 5'(CONV_CLKS - 1)) begin // R5
              cnt_r    <= '0;
              approx_r <= '0;
              if (dual && !second_r) begin
                second_r <= 1'b1; // R8
              end else begin
                state_r  <= ST_IDLE; // R7
                second_r <= 1'b0;
              end
            end else begin
              cnt_r <= cnt_r + 5'd1;
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Result registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      first_result_reg  <= '0;
      second_result_reg <= '0;
    end else if (state_r == ST_CONV && mclk_tick && cnt_r == 5'(CONV_CLKS - 1) && !wr_fall && !rd_fall) begin
      if (second_r) begin
        second_result_reg <= core_sample; // R8
      end else begin
        first_result_reg <= core_sample; // R7
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Busy output, polarity chosen by control bit
  logic busy_lvl;
  assign busy_lvl = (state_r != ST_IDLE) && !(rd_fall && !wr_fall);
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_int <= 1'b1;
    end else if (wr_fall) begin
      busy_int <= 1'b1; // R3 R11
    end else begin
      busy_int <= (busy_lvl && !done_pulse) ? ~ctl_r[CTL_POL_BIT] : ctl_r[CTL_POL_BIT]; // R7 R11
    end
  end

  // Read pointer and data port
  logic rd_sel_r;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_sel_r <= 1'b0;
    end else if (wr_fall) begin
      rd_sel_r <= 1'b0;
    end else if (rd_fall && state_r == ST_IDLE) begin
      // Step on each accepted read in dual mode, hold at first in single; strobes release together so rise cannot be used
      rd_sel_r <= dual ? ~rd_sel_r : 1'b0; // R10
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      data_out <= '0;
      data_oe  <= 1'b0;
    end else begin
      data_oe <= ~cs_s & ~rd_s & wr_s;
      if (rd_fall && state_r != ST_IDLE) begin
        data_out <= INVALID_DATA; // R1
      end else if (rd_fall) begin
        data_out <= rd_sel_r ? second_result_reg : first_result_reg; // R10
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl_out <= CTL_RESET;
    end else begin
      ctl_out <= ctl_r;
    end
  end
endmodule : adc_seq
`default_nettype wire

// File: adc_host.sv
// Host model driving the parallel port strobes
`timescale 1ns/1ps
`default_nettype none
module adc_host
  import adc_seq_pkg::*;
(
  // Clock
  input  wire logic              ref_clk,
  // Strobes and bus
  output logic                   cs_n,
  output logic                   wr_n,
  output logic                   rd_n,
  output logic      [DATA_W-1:0] data_in,
  input  wire logic [DATA_W-1:0] data_out
);
  initial begin
    cs_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    data_in = 10'h155;
  end
  // One write or read; bus released to inverted value afterwards
  task automatic strobe(input logic w, input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] r);
    @(posedge ref_clk);
    cs_n <= 1'b0;
    wr_n <= !w;
    rd_n <= w;
    data_in <= w ? d : ~data_in;
    repeat (8) @(posedge ref_clk);
    r = data_out;
    cs_n <= 1'b1;
    wr_n <= 1'b1;
    rd_n <= 1'b1;
    data_in <= ~data_in;
    repeat (4) @(posedge ref_clk);
  endtask : strobe
endmodule : adc_host
`default_nettype wire

// File: adc_seq_chk.sv
// Port checker for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module adc_seq_chk
  import adc_seq_pkg::*;
#(
  parameter int DW = DATA_W
) (
  input wire logic          ref_clk,
  input wire logic          arst_n,
  input wire logic          master_clock_input,
  input wire logic          cs_n,
  input wire logic          wr_n,
  input wire logic          rd_n,
  input wire logic [DW-1:0] data_in,
  input wire logic [DW-1:0] data_out,
  input wire logic          data_oe,
  input wire logic [DW-1:0] core_sample,
  input wire logic          busy_int,
  input wire logic [DW-1:0] ctl_out,
  input wire logic [DW-1:0] first_result_reg,
  input wire logic [DW-1:0] second_result_reg
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  logic       mc_r;
  logic       bsy_r;
  logic       armed_r;
  logic [7:0] tick_r;
  wire  logic busy = busy_int != ctl_out[CTL_POL_BIT];
  // No completion before the first write; reset level is not a sequence end
  wire  logic done = armed_r && bsy_r && !busy && cs_n;
  // Master ticks since the last write
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mc_r <= 1'b0;
      bsy_r <= 1'b1;
      armed_r <= 1'b0;
      tick_r <= 8'h00;
    end else begin
      mc_r <= master_clock_input;
      bsy_r <= busy;
      armed_r <= armed_r | (!cs_n && !wr_n);
      if (!cs_n && !wr_n)
        tick_r <= 8'h00;
      else if (master_clock_input && !mc_r && wr_n && tick_r != 8'hFF)
        tick_r <= tick_r + 8'h01;
    end
  end
  a_read_drive_on: assert property ((!cs_n && !rd_n && wr_n) [*8] |-> data_oe)
    else $error("port not driven in read");
  a_idle_drive_off: assert property (cs_n [*8] |-> !data_oe)
    else $error("port driven while deselected");
  a_ctl_load: assert property ((!cs_n && !wr_n && rd_n) [*8] |-> ctl_out == data_in)
    else $error("control word not loaded");
  a_write_busy: assert property ($fell(wr_n) && !cs_n && rd_n |-> ##[3:7] busy)
    else $error("write did not raise busy");
  a_read_abort: assert property ($rose(data_oe) && $past(busy, 2) |-> ##[0:1] data_out == INVALID_DATA)
    else $error("aborted read not invalid");
  a_single_store: assert property (done && $past(cs_n, 6) && !ctl_out[CTL_DUAL_BIT] |-> first_result_reg == core_sample)
    else $error("first result not stored");
  a_dual_store: assert property (done && $past(cs_n, 6) && ctl_out[CTL_DUAL_BIT] |-> second_result_reg == core_sample)
    else $error("second result not stored");
  a_seq_length: assert property (done && $past(cs_n, 6) |->
    (int'(tick_r) - ACQ_CLKS - CONV_CLKS * (ctl_out[CTL_DUAL_BIT] ? 2 : 1)) inside {-1, 0, 1})
    else $error("sequence length wrong");
endmodule : adc_seq_chk
bind adc_seq adc_seq_chk #(.DW(DW)) chk (
  .ref_clk(ref_clk), .arst_n(arst_n), .master_clock_input(master_clock_input), .cs_n(cs_n), .wr_n(wr_n),
  .rd_n(rd_n), .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .core_sample(core_sample),
  .busy_int(busy_int), .ctl_out(ctl_out), .first_result_reg(first_result_reg),
  .second_result_reg(second_result_reg)
);
`default_nettype wire

// File: adc_seq_tb_top.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module adc_seq_tb_top;
  import adc_seq_pkg::*;
  logic              ref_clk;
  logic              arst_n;
  logic              master_clock_input;
  logic              cs_n;
  logic              wr_n;
  logic              rd_n;
  logic [DATA_W-1:0] data_in;
  logic [DATA_W-1:0] data_out;
  logic [DATA_W-1:0] core_sample;
  logic              busy_int;
  logic [DATA_W-1:0] q;
  int                n_fail;
  int                n_tests;
  int                cycles;
  adc_seq dut (
    .ref_clk(ref_clk), .arst_n(arst_n), .master_clock_input(master_clock_input), .cs_n(cs_n),
    .wr_n(wr_n), .rd_n(rd_n), .data_in(data_in), .data_out(data_out), .data_oe(),
    .core_sample(core_sample), .busy_int(busy_int), .ctl_out(), .first_result_reg(), .second_result_reg()
  );
  adc_host host (
    .ref_clk(ref_clk), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .data_in(data_in), .data_out(data_out)
  );
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    master_clock_input = 1'b0;
    forever begin
      repeat (4) @(posedge ref_clk);
      master_clock_input <= ~master_clock_input;
    end
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic ticks(input int n);
    repeat (n) @(posedge master_clock_input);
    @(posedge ref_clk);
  endtask : ticks
  task automatic wait_idle(input logic lvl);
    for (int i = 0; i < 600 && busy_int !== lvl; i++) @(posedge ref_clk);
    check("idle level", busy_int, lvl);
  endtask : wait_idle
  task automatic t_single();
    core_sample <= 10'h2A5;
    host.strobe(1'b1, 10'h000, q);
    check("busy", busy_int, 1'b1);
    wait_idle(1'b0);
    host.strobe(1'b0, 10'h000, q);
    check("single read", q, 10'h2A5);
    host.strobe(1'b0, 10'h000, q);
    check("single reread", q, 10'h2A5);
    $display("single test done");
  endtask : t_single
  task automatic t_dual();
    core_sample <= 10'h0C3;
    host.strobe(1'b1, 10'h040, q);
    ticks(26);
    check("busy between", busy_int, 1'b1);
    core_sample <= 10'h13C;
    wait_idle(1'b0);
    for (int i = 0; i < 3; i++) begin
      host.strobe(1'b0, 10'h000, q);
      check("dual read", q, i[0] ? 10'h13C : 10'h0C3);
    end
    $display("dual test done");
  endtask : t_dual
  task automatic t_wr_abort();
    core_sample <= 10'h0F0;
    host.strobe(1'b1, 10'h000, q);
    ticks(10);
    host.strobe(1'b1, 10'h200, q);
    check("busy at rewrite", busy_int, 1'b0);
    ticks(15);
    check("busy restarted", busy_int, 1'b0);
    wait_idle(1'b1);
    host.strobe(1'b0, 10'h000, q);
    check("result after abort", q, 10'h0F0);
    $display("write abort test done");
  endtask : t_wr_abort
  task automatic t_rd_abort();
    host.strobe(1'b1, 10'h000, q);
    ticks(8);
    host.strobe(1'b0, 10'h000, q);
    check("aborted read", q, INVALID_DATA);
    check("busy after abort", busy_int, 1'b0);
    $display("read abort test done");
  endtask : t_rd_abort
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  initial begin
    arst_n = 1'b0;
    core_sample = 10'h000;
    repeat (5) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(negedge ref_clk);
    check("reset busy", busy_int, 1'b1);
    @(negedge ref_clk);
    check("idle after reset", busy_int, 1'b0);
    t_single();
    t_dual();
    t_wr_abort();
    t_rd_abort();
    finish_test();
  end
endmodule : adc_seq_tb_top
`default_nettype wire
